/* File: verilog/olsc_pkg.sv */
// Package: register map, origin codes and reset values for the output line control block
package olsc_pkg;
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_ORIGIN   = 8'h00; // Output origin select, two bits per output
    localparam logic [7:0] OFS_LEVEL    = 8'h04; // Static level value, one bit per output
    localparam logic [7:0] OFS_HOLD     = 8'h08; // Static hold select, one bit per output
    localparam logic [7:0] OFS_TRIGGER  = 8'h0c; // Output trigger mask, write only, reads zero
    localparam logic [7:0] OFS_SNAPSHOT = 8'h10; // All lines level snapshot, read only

    // ****************************************
    // Field layout and codes
    // ****************************************
    localparam int         ORIGIN_W       = 2;     // Width of one origin select field
    localparam logic [1:0] ORIGIN_EXTERNAL = 2'h0; // Driven by the external event source
    localparam logic [1:0] ORIGIN_HOST     = 2'h1; // Host driven static level
    localparam logic [1:0] ORIGIN_PULSE    = 2'h2; // Pulse on host strobe
    localparam logic       HOLD_OFF       = 1'h0;  // Output follows static level at once
    localparam logic       HOLD_LATCH     = 1'h1;  // Output waits for the trigger mask
    localparam logic       LEVEL_OPEN     = 1'h0;  // Inactive: output circuit open
    localparam logic       LEVEL_CLOSED   = 1'h1;  // Active: output circuit closed

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] RST_ORIGIN = 32'h0000_0000; // All outputs on external source
    localparam logic [31:0] RST_LEVEL  = 32'h0000_0000; // All levels inactive
    localparam logic [31:0] RST_HOLD   = 32'h0000_0000; // Latch mode off
    localparam logic [31:0] RST_LATCH  = 32'h0000_0000; // Latched levels open

    // AHB-Lite transfer type with the address-phase bit
    localparam int          HTRANS_ACTIVE_BIT = 1;  // NONSEQ or SEQ
endpackage

/* File: verilog/olsc_output_line_ctrl.sv */
// Module: host control of general purpose output lines behind an AHB-Lite slave
// Contract
// - Inactive static level opens the output circuit
// - Active static level closes the output circuit
// - Hold off: output follows static level immediately
// - Hold latch: pin waits for trigger mask
// - Level and latch act only when host driven
// - Snapshot returns live level of all lines
// - Mask one applies latch or fires pulse
// - Mask bit zero drives output one, upward
// - Mask acts on pulse or latched-host outputs
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module olsc_output_line_ctrl #(
    parameter int N_IN  = 2, // Input lines, numbered first in the snapshot
    parameter int N_OUT = 2  // Output lines, numbered after the inputs
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [7:0]        haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic [N_IN-1:0]   in_line,      // Input pins, asynchronous
    input  wire logic [N_OUT-1:0]  ext_level,    // External event source level, same clock
    input  wire logic [N_OUT-1:0]  pulse_level,  // Pulse generator level, same clock
    output logic      [N_OUT-1:0]  pulse_fire,   // One-cycle request to the pulse generator
    output logic      [N_OUT-1:0]  out_closed    // 1 = output circuit closed
);
    // ****************************************
    // Registers and state
    // ****************************************
    logic [2*N_OUT-1:0] origin_sel;        // Output origin select per output
    logic [N_OUT-1:0]   static_level;      // Static level value per output
    logic [N_OUT-1:0]   hold_sel;          // Static hold select per output
    logic [N_OUT-1:0]   latched_level;     // Level held while in latch mode
    logic [N_IN-1:0]    in_meta;           // First synchroniser stage
    logic [N_IN-1:0]    in_sync;           // Synchronised input lines
    logic               wr_pend;           // Write data phase pending
    logic [7:0]         wr_addr;           // Address of the pending write
    logic               addr_phase;        // Transfer taken this edge
    logic               trig_wr;           // Trigger mask write in data phase
    logic [N_OUT-1:0]   host_ctl;          // Output is host driven
    logic [N_OUT-1:0]   pulse_ctl;         // Output is pulse on host strobe
    logic [N_OUT-1:0]   next_out;          // Live pin level
    logic [31:0]        snapshot;          // All lines level snapshot

    // Never stall, always OKAY: every register answers in zero wait states
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign addr_phase = hsel && hready && htrans[olsc_pkg::HTRANS_ACTIVE_BIT];
    assign trig_wr    = wr_pend && (wr_addr == olsc_pkg::OFS_TRIGGER);

    // ****************************************
    // Per output decode and pin level
    // ****************************************
    generate
        for (genvar i = 0; i < N_OUT; i++) begin : g_out
            assign host_ctl[i]  = origin_sel[2*i +: 2] == olsc_pkg::ORIGIN_HOST;
            assign pulse_ctl[i] = origin_sel[2*i +: 2] == olsc_pkg::ORIGIN_PULSE;
            // Host driven: level directly or via latch; other origins pass through
            assign next_out[i] = host_ctl[i]
                ? ((hold_sel[i] == olsc_pkg::HOLD_LATCH) ? latched_level[i]
                                                         : static_level[i])
                : (pulse_ctl[i] ? pulse_level[i] : ext_level[i]);
        end
    endgenerate

    // Pin level is combinational so a static level change lands at once
    assign out_closed = next_out;

    // Snapshot: input lines first, then outputs, line one in bit zero
    assign snapshot = 32'({next_out, in_sync});

    // ****************************************
    // Input synchroniser
    // ****************************************
    // Two stages; only the second stage feeds the snapshot
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_meta <= '0;
            in_sync <= '0;
        end else begin
            in_meta <= in_line;
            in_sync <= in_meta;
        end
    end

    // ****************************************
    // AHB-Lite address phase capture
    // ****************************************
    // Writes land in the data phase, when hwdata is valid
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_phase && hwrite;
            wr_addr <= haddr;
        end
    end

    // Read data captured at the address edge: the live level at the moment of the read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            case (haddr)
                olsc_pkg::OFS_ORIGIN:   hrdata <= 32'(origin_sel);
                olsc_pkg::OFS_LEVEL:    hrdata <= 32'(static_level);
                olsc_pkg::OFS_HOLD:     hrdata <= 32'(hold_sel);
                olsc_pkg::OFS_SNAPSHOT: hrdata <= snapshot;
                default:                hrdata <= 32'h0000_0000;             // Trigger, unmapped
            endcase
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            origin_sel   <= olsc_pkg::RST_ORIGIN[2*N_OUT-1:0];
            static_level <= olsc_pkg::RST_LEVEL[N_OUT-1:0];
            hold_sel     <= olsc_pkg::RST_HOLD[N_OUT-1:0];
        end else if (wr_pend) begin
            case (wr_addr)
                olsc_pkg::OFS_ORIGIN: origin_sel   <= hwdata[2*N_OUT-1:0];
                olsc_pkg::OFS_LEVEL:  static_level <= hwdata[N_OUT-1:0];
                olsc_pkg::OFS_HOLD:   hold_sel     <= hwdata[N_OUT-1:0];
                default: ;                                                    // Writes ignored
            endcase
        end
    end

    // ****************************************
    // Trigger mask: latch apply and pulse fire
    // ****************************************
    // Bit i acts on output i+1; zero bits and other origins leave state alone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latched_level <= olsc_pkg::RST_LATCH[N_OUT-1:0];
            pulse_fire    <= '0;
        end else begin
            for (int i = 0; i < N_OUT; i++) begin
                pulse_fire[i] <= trig_wr && hwdata[i] && pulse_ctl[i];
                if (trig_wr && hwdata[i] && host_ctl[i]
                    && hold_sel[i] == olsc_pkg::HOLD_LATCH) begin
                    latched_level[i] <= static_level[i];
                end
            end
        end
    end

    // ****************************************
    // Assertions and covers
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    generate
        for (genvar i = 0; i < N_OUT; i++) begin : g_chk
            property p_open_inactive;
                host_ctl[i] && hold_sel[i] == olsc_pkg::HOLD_OFF
                    && static_level[i] == olsc_pkg::LEVEL_OPEN |-> !out_closed[i];
            endproperty
            a_open_inactive: assert property (p_open_inactive)
                else $error("Inactive static level did not open the output");
            property p_close_active;
                host_ctl[i] && !hold_sel[i] && static_level[i] |-> out_closed[i];
            endproperty
            a_close_active: assert property (p_close_active)
                else $error("Active static level did not close the output");
            property p_follow_now;
                wr_pend && wr_addr == olsc_pkg::OFS_LEVEL && host_ctl[i] && !hold_sel[i]
                    && !(wr_addr == olsc_pkg::OFS_HOLD)
                    |=> out_closed[i] == $past(hwdata[i]) || !host_ctl[i] || hold_sel[i];
            endproperty
            a_follow_now: assert property (p_follow_now)
                else $error("Static level change did not reach the pin next cycle");
            property p_latch_holds;
                host_ctl[i] && hold_sel[i] && !trig_wr ##1 host_ctl[i] && hold_sel[i]
                    |-> $stable(out_closed[i]);
            endproperty
            a_latch_holds: assert property (p_latch_holds)
                else $error("Latched output changed without a trigger");
            property p_other_origin;
                !host_ctl[i] && !pulse_ctl[i] |-> out_closed[i] == ext_level[i];
            endproperty
            a_other_origin: assert property (p_other_origin)
                else $error("Non host origin did not pass the external level");
            property p_apply_latch;
                trig_wr && hwdata[i] && host_ctl[i] && hold_sel[i]
                    |=> latched_level[i] == $past(static_level[i]);
            endproperty
            a_apply_latch: assert property (p_apply_latch)
                else $error("Trigger bit did not apply the latched level");
            property p_pulse_fire;
                trig_wr && hwdata[i] && pulse_ctl[i] |=> pulse_fire[i] ##1 !pulse_fire[i]
                    || $past(trig_wr);
            endproperty
            a_pulse_fire: assert property (p_pulse_fire)
                else $error("Trigger bit did not fire one pulse");
            property p_zero_bit;
                trig_wr && !hwdata[i] |=> !pulse_fire[i] && $stable(latched_level[i]);
            endproperty
            a_zero_bit: assert property (p_zero_bit)
                else $error("Zero trigger bit changed an output");
        end
    endgenerate

    property p_bit_order;
        trig_wr && hwdata[0] && pulse_ctl[0] && !hwdata[N_OUT-1] |=> pulse_fire[0]
            && (N_OUT == 1 || !pulse_fire[N_OUT-1]);
    endproperty
    a_bit_order: assert property (p_bit_order)
        else $error("Trigger bit zero did not act on output one");
    property p_snapshot;
        addr_phase && !hwrite && haddr == olsc_pkg::OFS_SNAPSHOT |=> hrdata == $past(snapshot);
    endproperty
    a_snapshot: assert property (p_snapshot)
        else $error("Snapshot read did not return the live line levels");

    c_pulse: cover property (trig_wr ##1 pulse_fire != '0);
    c_latch: cover property (trig_wr ##1 $changed(latched_level));
    c_snap:  cover property (addr_phase && !hwrite && haddr == olsc_pkg::OFS_SNAPSHOT);
endmodule

/* File: bench/olsc_pulse_model.sv */
// Model of the pulse generator that answers the block's pulse requests
`timescale 1ns/1ps
module olsc_pulse_model #(
    parameter int N_OUT = 2, // Output lines served
    parameter int PW    = 4  // Pulse width in cycles, plain default
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [N_OUT-1:0] pulse_fire,
    output logic      [N_OUT-1:0] pulse_level
);
    // ****************************************
    // One counter per line
    // ****************************************
    int cnt [N_OUT]; // Cycles of pulse left
    // A request restarts the pulse; the level drops when the count runs out
    // Reset test sits outside the loop so the asynchronous branch stays plain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < N_OUT; i++) cnt[i] <= 0;
        end else begin
            for (int i = 0; i < N_OUT; i++) begin
                if (pulse_fire[i]) begin
                    cnt[i] <= PW;
                end else if (cnt[i] > 0) begin
                    cnt[i] <= cnt[i] - 1;
                end
            end
        end
    end
    // Level is high only while a count remains
    always_comb begin
        for (int i = 0; i < N_OUT; i++) pulse_level[i] = (cnt[i] > 0);
    end
endmodule

/* File: bench/olsc_output_line_ctrl_tb.sv */
// Testbench: register bus, static, latched and pulsed outputs, snapshot
`timescale 1ns/1ps
module olsc_output_line_ctrl_tb;
    // ****************************************
    // Signals
    // ****************************************
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0, in_line = 2'h0, ext_level = 2'h2;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic        hreadyout, hresp;
    logic [1:0]  pulse_level, pulse_fire, out_closed;
    int          err_total = 0, checked = 0, cyc = 0;
    always #5 hclk = ~hclk; // 100 MHz
    olsc_output_line_ctrl #(.N_IN(2), .N_OUT(2)) olsc_output_line_ctrl_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .in_line(in_line),
        .ext_level(ext_level), .pulse_level(pulse_level), .pulse_fire(pulse_fire),
        .out_closed(out_closed));
    olsc_pulse_model #(.N_OUT(2), .PW(4)) olsc_pulse_model_inst (
        .hclk(hclk), .hresetn(hresetn), .pulse_fire(pulse_fire),
        .pulse_level(pulse_level));
    // ****************************************
    // Verdict, compare and bus tasks
    // ****************************************
    task automatic give_verdict();
        if (err_total == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Compares one value; case equality keeps unknowns from passing
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checked++;
        if (got !== ex) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // Single write, entered just after a rising edge
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    // Single read; data taken at the edge that ends the data phase
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    // Reset values, write-only and unmapped places read zero
    task automatic s_reset();
        logic [7:0] al [5];
        al = '{olsc_pkg::OFS_ORIGIN, olsc_pkg::OFS_LEVEL, olsc_pkg::OFS_HOLD,
               olsc_pkg::OFS_TRIGGER, 8'h14};
        chk("out_reset", {30'h0, ext_level}, {30'h0, out_closed});
        chk("hresp", 32'h0, {31'h0, hresp});
        foreach (al[i]) begin
            bus_rd(al[i], rd);
            chk("reg_reset", 32'h0, rd);
        end
    endtask
    // Hold off: level shows at once, only on host driven outputs
    task automatic s_static();
        bus_wr(olsc_pkg::OFS_ORIGIN, 32'h5);
        #1 chk("open", 32'h0, {30'h0, out_closed});
        bus_wr(olsc_pkg::OFS_LEVEL, 32'h3);
        #1 chk("closed", 32'h3, {30'h0, out_closed});
        bus_wr(olsc_pkg::OFS_ORIGIN, 32'h1);
        #1 chk("ext_mix", {30'h0, ext_level[1], 1'b1}, {30'h0, out_closed});
        ext_level <= 2'h0;
        @(posedge hclk);
        #1 chk("ext_low", 32'h1, {30'h0, out_closed});
        ext_level <= 2'h2;
        bus_rd(olsc_pkg::OFS_LEVEL, rd);
        chk("level_rb", 32'h3, rd);
    endtask
    // Latch mode: pin waits for the mask, one bit per output
    task automatic s_latch();
        bus_wr(olsc_pkg::OFS_ORIGIN, 32'h5);
        bus_wr(olsc_pkg::OFS_LEVEL, 32'h0);
        bus_wr(olsc_pkg::OFS_HOLD, 32'h3);
        bus_wr(olsc_pkg::OFS_LEVEL, 32'h3);
        #1 chk("latch_wait", 32'h0, {30'h0, out_closed});
        bus_wr(olsc_pkg::OFS_TRIGGER, 32'h1);
        #1 chk("latch_bit1", 32'h1, {30'h0, out_closed});
        bus_wr(olsc_pkg::OFS_TRIGGER, 32'h0);
        #1 chk("latch_zero", 32'h1, {30'h0, out_closed});
        bus_wr(olsc_pkg::OFS_TRIGGER, 32'h2);
        #1 chk("latch_bit2", 32'h3, {30'h0, out_closed});
    endtask
    // Pulse mode: mask fires a one-cycle request; other outputs stay quiet
    task automatic s_pulse();
        bus_wr(olsc_pkg::OFS_ORIGIN, 32'h8);
        bus_wr(olsc_pkg::OFS_TRIGGER, 32'h3);
        #1 chk("fire", 32'h2, {30'h0, pulse_fire});
        @(posedge hclk);
        #1 chk("fire_end", 32'h0, {30'h0, pulse_fire});
        chk("pulse_pin", 32'h1, {31'h0, out_closed[1]});
        bus_wr(olsc_pkg::OFS_TRIGGER, 32'h0);
        #1 chk("fire_zero", 32'h0, {30'h0, pulse_fire});
        bus_wr(olsc_pkg::OFS_ORIGIN, 32'h2);
        bus_wr(olsc_pkg::OFS_TRIGGER, 32'h1);
        #1 chk("fire_bit1", 32'h1, {30'h0, pulse_fire});
    endtask
    // Snapshot: inputs first, outputs after them
    task automatic s_snap();
        bus_wr(olsc_pkg::OFS_ORIGIN, 32'h5);
        bus_wr(olsc_pkg::OFS_HOLD, 32'h0);
        bus_wr(olsc_pkg::OFS_LEVEL, 32'h2);
        in_line <= 2'h1;
        repeat (3) @(posedge hclk);
        bus_rd(olsc_pkg::OFS_SNAPSHOT, rd);
        chk("snapshot", 32'h9, rd);
    endtask
    // ****************************************
    // Sequence and timeout
    // ****************************************
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        s_reset();
        s_static();
        s_latch();
        s_pulse();
        s_snap();
        give_verdict();
    end
    // A hang is cut short well past the expected run length
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            give_verdict();
        end
    end
endmodule
